// *** sfe_consts.svh ***
// constants of the serial flash front end: opcodes, sector map, reset values
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH

// command opcodes
`define SFE_OPC_READ    8'h03
`define SFE_OPC_PROG    8'h02
`define SFE_OPC_SEQ     8'had
`define SFE_OPC_ER4K    8'h20
`define SFE_OPC_ER32K   8'h52
`define SFE_OPC_ER64K   8'hd8
`define SFE_OPC_ERCHIP  8'h60
`define SFE_OPC_PROT    8'h36
`define SFE_OPC_UNPROT  8'h39

// byte shifted out when no read data is waiting
`define SFE_IDLE_BYTE   8'hff

// erase block masks over the 20-bit byte address
`define SFE_MASK_4K     20'h00fff
`define SFE_MASK_32K    20'h07fff
`define SFE_MASK_64K    20'h0ffff
`define SFE_MASK_CHIP   20'hfffff
`define SFE_ADDR_ZERO   20'h00000

// sector map: fifteen 64k sectors, then 16k, 8k, 8k, 32k boot sector
`define SFE_SMALL_BASE  20'hf0000
`define SFE_16K_END     20'hf4000
`define SFE_8KA_END     20'hf6000
`define SFE_8KB_END     20'hf8000
`define SFE_SEC_16K     5'h0f
`define SFE_SEC_8KA     5'h10
`define SFE_SEC_8KB     5'h11
`define SFE_SEC_BOOT    5'h12
`define SFE_NUM_SEC     19
`define SFE_PROT_RST    19'h7ffff

// transfer sizes
`define SFE_PAGE_MAX    9'h100
`define SFE_ADR_LAST    2'h2
`define SFE_FIFO_DEPTH  8
`define SFE_FIFO_WIDTH  28

`endif

// *** sfe_pkg.sv ***
// types shared by the serial flash front end
package sfe_pkg;

   typedef enum logic [3:0] {
      SFE_NONE, SFE_READ, SFE_PROG, SFE_SEQ, SFE_ER4K,
      SFE_ER32K, SFE_ER64K, SFE_ERCHIP, SFE_PROT, SFE_UNPROT
   } sfe_op_t;

   typedef enum logic [1:0] {FS_OPC, FS_ADR, FS_BODY, FS_SKIP} sfe_fs_t;

   // operation handed to the array side
   typedef struct packed {
      sfe_op_t      op;
      logic [19:0]  addr;
      logic [8:0]   count;
      logic         refused;
   } sfe_req_t;

   // one program byte with its target address
   typedef struct packed {
      logic [19:0]  addr;
      logic [7:0]   data;
   } sfe_wr_t;

endpackage

// *** sfe_front_end.sv ***
// serial flash front end: link shifter, command decoder, sector protection, program fifo
// Operation
// - The link works with host clock modes 0 and 3, and the host uses only those two.
// - With select high the device is deselected, idles in standby unless an internal operation runs, and floats its output.
// - Serial input bits are ignored while the device is deselected.
// - Operations start on the select falling edge and end on its rising edge.
// - After select rises on a program or erase, standby is on for two clock cycles, then drops until the internal operation finishes.
// - Command, address and write data are sampled on each rising serial clock edge.
// - Read data changes on each falling serial clock edge for the host to sample on the next rise.
// - A low write-protect input locks protected sectors against protection changes.
// - An undriven write-protect input counts as high, leaving hardware locking off.
// - Erases come in 4k, 32k and 64k blocks and as a full array erase.
// - Page program writes one to 256 bytes within a page, and a sequential program mode exists.
// - The array is split into fifteen 64k sectors, one 16k, two 8k and one 32k top boot sector.
// - Each sector has its own protect bit; a program is refused when its start sector is protected, an erase when any sector it touches is.
`include "sfe_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sfe_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           in_valid,
   output logic                in_ready,
   input  wire logic [W-1:0]   in_data,
   output logic                out_valid,
   input  wire logic           out_ready,
   output logic [W-1:0]        out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] wr_nxt;
   logic [AW-1:0] rd_r;
   logic [AW-1:0] rd_nxt;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   logic          push;
   logic          pop;

   // honest full and empty from the fill count
   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count next values
   always_comb
   begin
      wr_nxt  = push ? ((wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt  = pop  ? ((rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1) : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage, written only at the write index
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wr_r] <= in_data;
   end
endmodule // sfe_fifo

module sfe_front_end (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              spi_clk,
   input  wire logic              cs_n,
   input  wire logic              si,
   output logic                   so_o,
   output logic                   so_oe,
   input  wire logic              wp_n,
   output logic                   req_valid,
   output sfe_pkg::sfe_req_t      req,
   output logic                   wr_valid,
   input  wire logic              wr_ready,
   output sfe_pkg::sfe_wr_t       wr_data,
   input  wire logic              rd_valid,
   output logic                   rd_ready,
   input  wire logic [7:0]        rd_data,
   input  wire logic              array_done,
   output logic                   busy,
   output logic                   standby,
   output logic                   overrun
);
   // link domain
   logic [2:0]  rx_cnt_r;
   logic [2:0]  rx_cnt_nxt;
   logic        started_r;
   logic [6:0]  rx_sr_r;
   logic [6:0]  rx_sr_nxt;
   logic [7:0]  rx_byte_r;
   logic [7:0]  rx_byte_nxt;
   logic        rx_tog_r;
   logic        rx_tog_nxt;
   logic [7:0]  so_sr_r;
   logic [7:0]  so_sr_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic        treq_s1_r;
   logic        treq_s2_r;
   logic        byte_edge;
   // system domain
   logic        cs_s1_r, cs_s2_r, cs_d1_r, cs_d2_r, cs_d3_r;
   logic        wp_s1_r, wp_s2_r;
   logic        rxt_s1_r, rxt_s2_r, rxt_s3_r;
   logic        ack_s1_r, ack_s2_r;
   logic        new_byte;
   logic        frame_start;
   logic        frame_end;
   logic [7:0]  tx_hold_r;
   logic [7:0]  tx_hold_nxt;
   logic        tx_req_r;
   logic        tx_req_nxt;
   sfe_pkg::sfe_fs_t   fs_r, fs_nxt;
   sfe_pkg::sfe_op_t   op_r, op_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic [1:0]  adr_cnt_r, adr_cnt_nxt;
   logic [8:0]  cnt_r, cnt_nxt;
   logic        refused_r, refused_nxt;
   logic [`SFE_NUM_SEC-1:0] prot_r, prot_nxt;
   logic        busy_r, busy_nxt;
   logic        req_valid_r, req_valid_nxt;
   sfe_pkg::sfe_req_t  req_r, req_nxt;
   logic        overrun_r, overrun_nxt;
   logic        standby_r, standby_nxt;
   logic        push;
   logic        fifo_in_ready;
   sfe_pkg::sfe_wr_t   push_word;
   logic        lk;
   logic [4:0]  sec;

   // sector number of a byte address
   function automatic logic [4:0] sector_of(input logic [19:0] a);
      if (a < `SFE_SMALL_BASE)
         return {1'b0, a[19:16]};
      else if (a < `SFE_16K_END)
         return `SFE_SEC_16K;
      else if (a < `SFE_8KA_END)
         return `SFE_SEC_8KA;
      else if (a < `SFE_8KB_END)
         return `SFE_SEC_8KB;
      else
         return `SFE_SEC_BOOT;
   endfunction

   // true when any sector the erase block touches is protected
   function automatic logic range_locked(input logic [`SFE_NUM_SEC-1:0] p,
                                         input sfe_pkg::sfe_op_t o,
                                         input logic [19:0] a);
      logic [19:0] m;
      logic [4:0]  lo;
      logic [4:0]  hi;
      logic        r;
      unique case (o)
         sfe_pkg::SFE_ER4K:  m = `SFE_MASK_4K;
         sfe_pkg::SFE_ER32K: m = `SFE_MASK_32K;
         sfe_pkg::SFE_ER64K: m = `SFE_MASK_64K;
         default:            m = `SFE_MASK_CHIP;
      endcase
      lo = sector_of(a & ~m);
      hi = sector_of(a | m);
      r  = 1'b0;
      for (int i = 0; i < `SFE_NUM_SEC; i++)
         if (5'(i) >= lo && 5'(i) <= hi && p[i])
            r = 1'b1;
      return r;
   endfunction

   // output floats unless selected
   assign so_oe = ~cs_n;
   assign so_o  = so_sr_r[7];
   assign byte_edge = started_r && (rx_cnt_r == 3'h0);

   // receive shifter next values, msb first
   always_comb
   begin
      rx_cnt_nxt  = rx_cnt_r + 3'h1;
      rx_sr_nxt   = {rx_sr_r[5:0], si};
      rx_byte_nxt = rx_byte_r;
      rx_tog_nxt  = rx_tog_r;
      if (rx_cnt_r == 3'h7)
      begin
         rx_byte_nxt = {rx_sr_r, si};
         rx_tog_nxt  = ~rx_tog_r;
      end
   end

   // frame state held in reset while deselected
   always_ff @(posedge spi_clk or posedge cs_n)
   begin
      if (cs_n)
      begin
         rx_cnt_r  <= 3'h0;
         started_r <= 1'b0;
         rx_sr_r   <= 7'h00;
      end
      else
      begin
         rx_cnt_r  <= rx_cnt_nxt;
         started_r <= 1'b1;
         rx_sr_r   <= rx_sr_nxt;
      end
   end

   // received byte and its toggle survive the frame end
   always_ff @(posedge spi_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_byte_r <= 8'h00;
         rx_tog_r  <= 1'b0;
      end
      else
      begin
         rx_byte_r <= rx_byte_nxt;
         rx_tog_r  <= rx_tog_nxt;
      end
   end

   // transmit shifter: load at each byte boundary, else shift
   always_comb
   begin
      so_sr_nxt = {so_sr_r[6:0], 1'b1};
      ack_nxt   = ack_r;
      if (byte_edge)
      begin
         so_sr_nxt = `SFE_IDLE_BYTE;
         if (treq_s2_r != ack_r)
         begin
            so_sr_nxt = tx_hold_r;
            ack_nxt   = ~ack_r;
         end
      end
   end

   // first fall in mode 3 precedes any rise and is skipped by byte_edge
   always_ff @(negedge spi_clk or posedge cs_n)
   begin
      if (cs_n)
         so_sr_r <= `SFE_IDLE_BYTE;
      else
         so_sr_r <= so_sr_nxt;
   end

   // request synchroniser and acknowledge toggle on the falling edge
   always_ff @(negedge spi_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         treq_s1_r <= 1'b0;
         treq_s2_r <= 1'b0;
         ack_r     <= 1'b0;
      end
      else
      begin
         treq_s1_r <= tx_req_r;
         treq_s2_r <= treq_s1_r;
         ack_r     <= ack_nxt;
      end
   end

   // pin and toggle synchronisers into the system clock
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         cs_d1_r  <= 1'b1;
         cs_d2_r  <= 1'b1;
         cs_d3_r  <= 1'b1;
         wp_s1_r  <= 1'b1;
         wp_s2_r  <= 1'b1;
         rxt_s1_r <= 1'b0;
         rxt_s2_r <= 1'b0;
         rxt_s3_r <= 1'b0;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end
      else
      begin
         cs_s1_r  <= cs_n;
         cs_s2_r  <= cs_s1_r;
         cs_d1_r  <= cs_s2_r;
         cs_d2_r  <= cs_d1_r;
         cs_d3_r  <= cs_d2_r;
         wp_s1_r  <= wp_n;
         wp_s2_r  <= wp_s1_r;
         rxt_s1_r <= rx_tog_r;
         rxt_s2_r <= rxt_s1_r;
         rxt_s3_r <= rxt_s2_r;
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // frame edges; the end lags so the last byte lands first
   assign frame_start = cs_d1_r && !cs_s2_r;
   assign frame_end   = cs_d2_r && !cs_d3_r;
   assign new_byte    = rxt_s2_r ^ rxt_s3_r;
   assign sec         = sector_of(addr_r);
   assign lk          = range_locked(prot_r, op_r, addr_r);

   // read data hand-off to the link, one byte in flight
   always_comb
   begin
      rd_ready    = (op_r == sfe_pkg::SFE_READ) && (fs_r == sfe_pkg::FS_BODY) && (tx_req_r == ack_s2_r);
      tx_hold_nxt = tx_hold_r;
      tx_req_nxt  = tx_req_r;
      if (rd_valid && rd_ready)
      begin
         tx_hold_nxt = rd_data;
         tx_req_nxt  = ~tx_req_r;
      end
   end

   // command decoder, protection and operation issue
   always_comb
   begin
      fs_nxt        = fs_r;
      op_nxt        = op_r;
      addr_nxt      = addr_r;
      adr_cnt_nxt   = adr_cnt_r;
      cnt_nxt       = cnt_r;
      refused_nxt   = refused_r;
      prot_nxt      = prot_r;
      busy_nxt      = busy_r && !array_done;
      req_valid_nxt = 1'b0;
      req_nxt       = req_r;
      overrun_nxt   = overrun_r;
      push          = 1'b0;
      push_word     = '{addr: addr_r, data: rx_byte_r};
      if (frame_start)
      begin
         fs_nxt      = sfe_pkg::FS_OPC;
         op_nxt      = sfe_pkg::SFE_NONE;
         adr_cnt_nxt = 2'h0;
         cnt_nxt     = 9'h000;
         refused_nxt = 1'b0;
         overrun_nxt = 1'b0;
      end
      else if (new_byte)
      begin
         unique case (fs_r)
            sfe_pkg::FS_OPC:
            begin
               fs_nxt = sfe_pkg::FS_ADR;
               unique case (rx_byte_r)
                  `SFE_OPC_READ:   op_nxt = sfe_pkg::SFE_READ;
                  `SFE_OPC_PROG:   op_nxt = sfe_pkg::SFE_PROG;
                  `SFE_OPC_SEQ:    op_nxt = sfe_pkg::SFE_SEQ;
                  `SFE_OPC_ER4K:   op_nxt = sfe_pkg::SFE_ER4K;
                  `SFE_OPC_ER32K:  op_nxt = sfe_pkg::SFE_ER32K;
                  `SFE_OPC_ER64K:  op_nxt = sfe_pkg::SFE_ER64K;
                  `SFE_OPC_ERCHIP: op_nxt = sfe_pkg::SFE_ERCHIP;
                  `SFE_OPC_PROT:   op_nxt = sfe_pkg::SFE_PROT;
                  `SFE_OPC_UNPROT: op_nxt = sfe_pkg::SFE_UNPROT;
                  default:         op_nxt = sfe_pkg::SFE_NONE;
               endcase
               // nothing new is taken while an internal operation runs
               if (busy_r || op_nxt == sfe_pkg::SFE_NONE)
               begin
                  op_nxt = sfe_pkg::SFE_NONE;
                  fs_nxt = sfe_pkg::FS_SKIP;
               end
               else if (op_nxt == sfe_pkg::SFE_ERCHIP)
                  fs_nxt = sfe_pkg::FS_SKIP;
            end
            sfe_pkg::FS_ADR:
            begin
               addr_nxt    = {addr_r[11:0], rx_byte_r};
               adr_cnt_nxt = adr_cnt_r + 2'h1;
               if (adr_cnt_r == `SFE_ADR_LAST)
               begin
                  fs_nxt      = sfe_pkg::FS_BODY;
                  refused_nxt = prot_r[sector_of(addr_nxt)];
                  if (op_r == sfe_pkg::SFE_READ)
                  begin
                     req_valid_nxt = 1'b1;
                     req_nxt       = '{op: op_r, addr: addr_nxt, count: 9'h000, refused: 1'b0};
                  end
               end
            end
            sfe_pkg::FS_BODY:
            begin
               if (op_r == sfe_pkg::SFE_PROG || op_r == sfe_pkg::SFE_SEQ)
               begin
                  push = !refused_r;
                  if (!fifo_in_ready)
                     overrun_nxt = 1'b1;
                  // page program wraps inside its page, sequential crosses pages
                  if (op_r == sfe_pkg::SFE_PROG)
                     addr_nxt = {addr_r[19:8], addr_r[7:0] + 8'h01};
                  else
                     addr_nxt = addr_r + 20'h00001;
                  if (cnt_r != `SFE_PAGE_MAX || op_r == sfe_pkg::SFE_SEQ)
                     cnt_nxt = cnt_r + 9'h001;
               end
            end
            default:
            begin
               fs_nxt = sfe_pkg::FS_SKIP;
            end
         endcase
      end
      else if (frame_end)
      begin
         fs_nxt = sfe_pkg::FS_SKIP;
         op_nxt = sfe_pkg::SFE_NONE;
         req_nxt = '{op: op_r, addr: addr_r, count: cnt_r, refused: 1'b0};
         unique case (op_r)
            sfe_pkg::SFE_PROG, sfe_pkg::SFE_SEQ:
            begin
               if (fs_r == sfe_pkg::FS_BODY && cnt_r != 9'h000)
               begin
                  req_valid_nxt   = 1'b1;
                  req_nxt.refused = refused_r;
                  busy_nxt        = !refused_r;
               end
            end
            sfe_pkg::SFE_ER4K, sfe_pkg::SFE_ER32K, sfe_pkg::SFE_ER64K, sfe_pkg::SFE_ERCHIP:
            begin
               if (fs_r == sfe_pkg::FS_BODY || op_r == sfe_pkg::SFE_ERCHIP)
               begin
                  req_valid_nxt   = 1'b1;
                  req_nxt.refused = lk;
                  if (op_r == sfe_pkg::SFE_ERCHIP)
                     req_nxt.addr = `SFE_ADDR_ZERO;
                  busy_nxt        = !lk;
               end
            end
            sfe_pkg::SFE_PROT, sfe_pkg::SFE_UNPROT:
            begin
               if (fs_r == sfe_pkg::FS_BODY)
               begin
                  req_valid_nxt = 1'b1;
                  // write-protect low freezes protected sectors
                  if (op_r == sfe_pkg::SFE_UNPROT && !wp_s2_r)
                     req_nxt.refused = 1'b1;
                  else
                     prot_nxt[sec] = (op_r == sfe_pkg::SFE_PROT);
               end
            end
            default:
            begin
               req_valid_nxt = 1'b0;
            end
         endcase
      end
      standby_nxt = cs_s2_r && !busy_nxt;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fs_r        <= sfe_pkg::FS_SKIP;
         op_r        <= sfe_pkg::SFE_NONE;
         addr_r      <= 20'h00000;
         adr_cnt_r   <= 2'h0;
         cnt_r       <= 9'h000;
         refused_r   <= 1'b0;
         prot_r      <= `SFE_PROT_RST;
         busy_r      <= 1'b0;
         req_valid_r <= 1'b0;
         req_r       <= '0;
         overrun_r   <= 1'b0;
         standby_r   <= 1'b1;
         tx_hold_r   <= 8'h00;
         tx_req_r    <= 1'b0;
      end
      else
      begin
         fs_r        <= fs_nxt;
         op_r        <= op_nxt;
         addr_r      <= addr_nxt;
         adr_cnt_r   <= adr_cnt_nxt;
         cnt_r       <= cnt_nxt;
         refused_r   <= refused_nxt;
         prot_r      <= prot_nxt;
         busy_r      <= busy_nxt;
         req_valid_r <= req_valid_nxt;
         req_r       <= req_nxt;
         overrun_r   <= overrun_nxt;
         standby_r   <= standby_nxt;
         tx_hold_r   <= tx_hold_nxt;
         tx_req_r    <= tx_req_nxt;
      end
   end

   assign req_valid = req_valid_r;
   assign req       = req_r;
   assign busy      = busy_r;
   assign standby   = standby_r;
   assign overrun   = overrun_r;

   // program bytes buffered toward the array
   sfe_fifo #(
      .W (`SFE_FIFO_WIDTH),
      .D (`SFE_FIFO_DEPTH)
   ) u_wr_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_data)
   );
endmodule // sfe_front_end

`default_nettype wire

// *** sfe_front_end_props.sv ***
// port checker of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module sfe_front_end_props (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              cs_n,
   input wire logic              so_oe,
   input wire logic              req_valid,
   input wire sfe_pkg::sfe_req_t req,
   input wire logic              wr_valid,
   input wire logic              wr_ready,
   input wire sfe_pkg::sfe_wr_t  wr_data,
   input wire logic              array_done,
   input wire logic              busy,
   input wire logic              standby
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // frame held open, internally timed op accepted
   sequence s_sel; !cs_n [*4]; endsequence
   sequence s_timed;
      req_valid && !req.refused && req.op >= sfe_pkg::SFE_PROG && req.op <= sfe_pkg::SFE_ERCHIP;
   endsequence
   property p_float; so_oe == !cs_n; endproperty
   property p_active; s_sel |-> !standby; endproperty
   property p_stby; busy && $past(busy) |-> !standby; endproperty
   property p_done; busy && array_done && !req_valid |=> !busy; endproperty
   property p_issue; s_timed |=> busy; endproperty
   property p_refuse; req_valid && req.refused |=> !busy; endproperty
   property p_pulse; req_valid |=> !req_valid; endproperty
   property p_count;
      req_valid && req.op == sfe_pkg::SFE_PROG && !req.refused |-> req.count != 9'h000 && req.count <= 9'h100;
   endproperty
   property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data); endproperty
   a_float: assert property (p_float) else $error("output enable off select");
   a_active: assert property (p_active) else $error("standby in frame");
   a_stby: assert property (p_stby) else $error("standby while busy");
   a_done: assert property (p_done) else $error("busy after done");
   a_issue: assert property (p_issue) else $error("busy not set");
   a_refuse: assert property (p_refuse) else $error("busy on refusal");
   a_pulse: assert property (p_pulse) else $error("issue not a pulse");
   a_count: assert property (p_count) else $error("bad program count");
   a_hold: assert property (p_hold) else $error("fifo head moved");
endmodule // sfe_front_end_props
`default_nettype wire

// *** sfe_host_model.sv ***
// host spi controller model: select, link clock, serial input
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
   output var logic spi_clk,
   output var logic cs_n,
   output var logic si,
   input  wire logic so
);
   logic mode3;
   // idle levels
   initial
   begin
      mode3 = 1'b0;
      spi_clk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // released data line wanders while deselected
   always #7 if (cs_n) si = ~si;
   // clock idle level picks mode 0 or 3
   task automatic set_mode(input logic m);
      mode3 = m;
      spi_clk = m;
   endtask
   // one framed transfer, msb first, link clock only inside
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      cs_n = 1'b0;
      #40;
      foreach (tx[i])
      begin
         for (int k = 7; k >= 0; k--)
         begin
            spi_clk = 1'b0;
            si = tx[i][k];
            #15 spi_clk = 1'b1;
            b[k] = so;
            #15;
         end
         rx.push_back(b);
      end
      spi_clk = mode3;
      #150 cs_n = 1'b1;
      #250;
   endtask
endmodule // sfe_host_model
`default_nettype wire

// *** tb_top.sv ***
// testbench of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wp_en = 1'b0, wr_ready = 1'b0, array_done = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic [1:0] rd_cnt = 2'h0;
   logic spi_clk, cs_n, si, so_o, so_oe, so_w, req_valid, wr_valid, rd_valid, rd_ready, busy, standby, overrun;
   tri1 wp_n;
   sfe_pkg::sfe_req_t req, got;
   sfe_pkg::sfe_wr_t wr_data;
   int error_cnt = 0, n_tests = 0, n_req = 0, cyc = 0;
   logic [7:0] rx[$];
   // pins: pulled-up protect, undriven output reads inverted
   assign wp_n = wp_en ? 1'b0 : 1'bz;
   assign so_w = so_oe ? so_o : ~so_o;
   assign rd_valid = rd_cnt != 2'h0;
   always #12.5 clk = ~clk;
   sfe_front_end sfe_front_end_i (.clk(clk), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
      .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n), .req_valid(req_valid), .req(req), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .array_done(array_done), .busy(busy), .standby(standby), .overrun(overrun));
   sfe_host_model sfe_host_model_i (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so_w));
   // array side, issue capture and timeout
   always @(posedge clk)
   begin
      if (rd_valid && rd_ready === 1'b1) rd_cnt <= rd_cnt - 2'h1;
      if (req_valid === 1'b1)
      begin
         got <= req;
         n_req <= n_req + 1;
      end
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   task automatic check(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_op;
      @(posedge clk) #1 array_done = 1'b1;
      @(posedge clk) #1 array_done = 1'b0;
   endtask
   // one frame that must issue exactly one operation
   task automatic op(input logic [7:0] tx[$], input logic [3:0] o, input logic [19:0] a, input logic r);
      int n0;
      n0 = n_req;
      sfe_host_model_i.frame(tx, rx);
      check(n_req - n0, 1);
      check({got.op, got.addr, got.refused}, {o, a, r});
      if (busy === 1'b1) finish_op;
   endtask
   task automatic t_read;
      for (int m = 0; m < 2; m++)
      begin
         sfe_host_model_i.set_mode(m[0]);
         @(posedge clk) #1 rd_data = 8'ha5 ^ m[7:0];
         rd_cnt = 2'h1;
         op({8'h03, 8'hf1, 8'h23, 8'h45, 8'h00, 8'h00, 8'h00}, sfe_pkg::SFE_READ, 20'h12345, 1'b0);
         check({rx[0], rx[4], rx[5], rx[6]}, {8'hff, 8'hff, 8'ha5 ^ m[7:0], 8'hff});
      end
      sfe_host_model_i.set_mode(1'b0);
   endtask
   task automatic t_prot;
      @(posedge clk) #1 wp_en = 1'b1;
      op({8'h39, 8'h00, 8'h00, 8'h00}, sfe_pkg::SFE_UNPROT, 20'h0, 1'b1);
      @(posedge clk) #1 wp_en = 1'b0;
      op({8'h39, 8'h00, 8'h00, 8'h00}, sfe_pkg::SFE_UNPROT, 20'h0, 1'b0);
      // issued address is the one after the last byte, wrapped in its page
      op({8'h02, 8'h01, 8'h00, 8'h00, 8'h11}, sfe_pkg::SFE_PROG, 20'h10001, 1'b1);
      check(wr_valid, 1'b0);
   endtask
   task automatic t_erase;
      logic [7:0] opc[4] = '{8'h20, 8'h52, 8'hd8, 8'h60};
      for (int i = 0; i < 4; i++)
         op({opc[i], 8'h00, 8'h00, 8'h00}, 4'(i + 4), 20'h0, i == 3);
   endtask
   // page wrap, fifo fill past full, busy frame ignored, drain
   task automatic t_prog;
      logic [7:0] tx[$];
      int n0;
      tx = {8'h02, 8'h00, 8'h00, 8'hfe};
      for (int i = 0; i < 10; i++) tx.push_back(8'h10 + i[7:0]);
      n0 = n_req;
      sfe_host_model_i.frame(tx, rx);
      check({got.op, got.count, busy, standby, overrun}, {sfe_pkg::SFE_PROG, 9'h00a, 3'b101});
      sfe_host_model_i.frame({8'h03, 8'h00, 8'h00, 8'h00}, rx);
      check(n_req - n0, 1);
      @(posedge clk) #1 wr_ready = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         check({wr_valid, wr_data}, {1'b1, 12'h000, 8'hfe + i[7:0], 8'h10 + i[7:0]});
         @(posedge clk) #1;
      end
      check(wr_valid, 1'b0);
      wr_ready = 1'b0;
      finish_op;
      repeat (3) @(posedge clk);
      #1 check({busy, standby}, 2'b01);
   endtask
   // sequential program crosses a page, then protect relocks sector 0
   task automatic t_seq;
      op({8'had, 8'h00, 8'h00, 8'hff, 8'h5a, 8'ha5}, sfe_pkg::SFE_SEQ, 20'h00101, 1'b0);
      @(posedge clk) #1 wr_ready = 1'b1;
      check({wr_valid, wr_data}, {1'b1, 20'h000ff, 8'h5a});
      @(posedge clk) #1 check({wr_valid, wr_data}, {1'b1, 20'h00100, 8'ha5});
      @(posedge clk) #1 wr_ready = 1'b0;
      check(wr_valid, 1'b0);
      op({8'h36, 8'h00, 8'h00, 8'h00}, sfe_pkg::SFE_PROT, 20'h0, 1'b0);
      op({8'h20, 8'h00, 8'h00, 8'h00}, sfe_pkg::SFE_ER4K, 20'h0, 1'b1);
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 check({standby, so_oe}, 2'b10);
      t_read;
      t_prot;
      t_erase;
      t_prog;
      t_seq;
      report_and_stop;
   end
endmodule // tb_top
bind sfe_front_end sfe_front_end_props sfe_front_end_props_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
   .so_oe(so_oe), .req_valid(req_valid), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_data(wr_data), .array_done(array_done), .busy(busy), .standby(standby));
`default_nettype wire
